// ### hw/msf_decode.sv
// Purpose: Map the four select levels onto one preset frequency
// Assumes: Levels already routed and synchronised
// Notes:   Purely combinational; the caller registers the result
`timescale 1ns/10ps
module msf_decode (
  input  wire logic sel_high,
  input  wire logic sel_mid,
  input  wire logic sel_low,
  input  wire logic sel_ext,
  input  wire logic [msf_pkg::NUM_PRESET-1:0][msf_pkg::PRESET_W-1:0] preset,
  output logic      hit,
  output logic [msf_pkg::PRESET_W-1:0] freq
);
  logic [2:0] code;    // {high, middle, low}
  logic [3:0] speed;   // Speed number 1..15, 0 with no select
  logic [3:0] slot;    // Preset slot, speed minus one
  logic       multi;   // Combination addresses an extended preset

  always_comb begin
    code  = {sel_high, sel_mid, sel_low};
    // Binary-style combination of the four inputs
    if (sel_ext) begin
      speed = {1'b1, code};
    end else if (code == 3'h3) begin
      speed = 4'h4;
    end else begin
      speed = {1'b0, code};
    end
    slot  = 4'(speed - 4'h1);
    multi = sel_ext || (code == 3'h3) || (code == 3'h5) ||
            (code == 3'h6) || (code == 3'h7);
    hit   = 1'b1;
    freq  = '0;
    // Each combination picks one slot, no ranking among them
    if (multi && preset[slot] != msf_pkg::NOT_SEL) begin
      freq = preset[slot];
    end else if (sel_ext && code == 3'h0) begin
      freq = preset[2];
    end else if (sel_low) begin
      freq = preset[2];
    end else if (sel_mid) begin
      freq = preset[1];
    end else if (sel_high) begin
      freq = preset[0];
    end else begin
      hit = 1'b0;
    end
  end
endmodule : msf_decode

// ### hw/msf_pkg.sv
// Purpose: Shared constants and types for the multi-speed frequency selector
// Assumes: Frequencies are held in 0.1 Hz steps, so 400 Hz is 4000
// Notes:   The not-selected marker 9999 lies above 4000 and never clashes
package msf_pkg;
  // Widths and counts
  localparam int PRESET_W   = 16;        // Preset word width
  localparam int FUNC_W     = 8;         // Terminal function code width
  localparam int ADDR_W     = 8;         // Register address width
  localparam int DATA_W     = 16;        // Register data width
  localparam int NUM_PRESET = 15;        // Speeds one to fifteen
  localparam int NUM_BASIC  = 3;         // High, middle, low slots

  // Preset values in 0.1 Hz steps
  localparam logic [PRESET_W-1:0] RST_HIGH = 16'h01F4;  // 50.0 Hz
  localparam logic [PRESET_W-1:0] RST_MID  = 16'h012C;  // 30.0 Hz
  localparam logic [PRESET_W-1:0] RST_LOW  = 16'h0064;  // 10.0 Hz
  localparam logic [PRESET_W-1:0] FREQ_MAX = 16'h0FA0;  // 400.0 Hz
  localparam logic [PRESET_W-1:0] NOT_SEL  = 16'h270F;  // Marker 9999

  // Terminal function codes
  localparam logic [FUNC_W-1:0] FN_LOW  = 8'h00;
  localparam logic [FUNC_W-1:0] FN_MID  = 8'h01;
  localparam logic [FUNC_W-1:0] FN_HIGH = 8'h02;
  localparam logic [FUNC_W-1:0] FN_EXT  = 8'h08;
  localparam logic [FUNC_W-1:0] FN_NONE = 8'hFF;

  // Operation mode codes and reset values
  localparam logic [2:0] MODE_EXT   = 3'h3;      // External operation
  localparam logic [2:0] MODE_COMB  = 3'h4;      // Panel/external combined
  localparam logic [2:0] RST_OPMODE = 3'h0;
  localparam logic [1:0] RST_REMOTE = 2'h0;
  localparam logic [1:0] RST_PWRITE = 2'h0;
  localparam logic [DATA_W-1:0] RST_UGROUP = 16'h0000;

  // Register word offsets
  localparam logic [ADDR_W-1:0] OFS_PRESET0 = 8'h00;  // Slots 0x00..0x0E
  localparam logic [ADDR_W-1:0] OFS_PRESET_END = 8'h0F;
  localparam logic [ADDR_W-1:0] OFS_REMOTE  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_OPMODE  = 8'h11;
  localparam logic [ADDR_W-1:0] OFS_PWRITE  = 8'h12;
  localparam logic [ADDR_W-1:0] OFS_UGROUP  = 8'h13;
  localparam logic [ADDR_W-1:0] OFS_TERM0   = 8'h18;  // Up to 8 terminals
  localparam logic [ADDR_W-1:0] OFS_FREQ    = 8'h20;  // Read only
  localparam logic [ADDR_W-1:0] OFS_STATE   = 8'h21;  // Read only

  // State register field positions
  localparam int STATE_SEL_LSB = 0;      // {ext, high, middle, low}
  localparam int STATE_SRC_LSB = 4;      // Frequency source, 3 bits
  localparam int STATE_EN_BIT  = 7;      // Multi-speed enabled

  // Frequency command source
  typedef enum logic [2:0] {
    SRC_NONE, SRC_JOG, SRC_MULTI, SRC_CUR, SRC_VOLT
  } msf_src_t;

  // Preset reset value per slot
  function automatic logic [PRESET_W-1:0] preset_reset(input int i);
    case (i)
      0:       return RST_HIGH;
      1:       return RST_MID;
      2:       return RST_LOW;
      default: return NOT_SEL;
    endcase
  endfunction : preset_reset

  // Terminals 0..2 carry low, middle, high; others start unassigned
  function automatic logic [FUNC_W-1:0] term_reset(input int i);
    case (i)
      0:       return FN_LOW;
      1:       return FN_MID;
      2:       return FN_HIGH;
      default: return FN_NONE;
    endcase
  endfunction : term_reset
endpackage : msf_pkg

// ### hw/msf_selector.sv
// Operation
// - High, middle, low select pick their presets
// - Presets span 0-400 Hz; extended allow 9999
// - Four inputs together pick speeds four to fifteen
// - Extended presets reset to not selected
// - Extension alone, speed eight unset, runs low
// - Several basic selects, combination unset: lowest-ranked input wins
// - Jog over multi-speed over current over voltage
// - Multi-speed only in operation modes 3, 4
// - Presets writable in panel or external mode
// - Extended presets have no mutual precedence
// - Non-zero remote function disables multi-speed
// - Terminal codes 0,1,2 assign low, middle, high
// - Code 8 assigns the speed-extension select
// - Presets writable while running, any write selection
// - Extended presets exposed only when user group zero
//
// Purpose: Multi-speed frequency command selection with register access
// Assumes: Frequencies in 0.1 Hz steps; jog and analog inputs are on mclk
// Notes:   Read data stand only in the cycle after the read strobe
`timescale 1ns/10ps
module msf_selector #(
  parameter int NUM_TERM = 7
) (
  input  wire logic                         mclk,
  input  wire logic                         rst,
  input  wire logic [msf_pkg::ADDR_W-1:0]   addr,
  input  wire logic [msf_pkg::DATA_W-1:0]   wdata,
  input  wire logic                         wr,
  input  wire logic                         rd,
  output logic      [msf_pkg::DATA_W-1:0]   rdata,
  input  wire logic [NUM_TERM-1:0]          term_in,
  input  wire logic                         jog_on,
  input  wire logic [msf_pkg::PRESET_W-1:0] jog_freq,
  input  wire logic                         cur_valid,
  input  wire logic [msf_pkg::PRESET_W-1:0] cur_freq,
  input  wire logic                         volt_valid,
  input  wire logic [msf_pkg::PRESET_W-1:0] volt_freq,
  output logic      [msf_pkg::PRESET_W-1:0] freq_cmd,
  output msf_pkg::msf_src_t                 freq_src,
  output logic                              multi_on
);
  // Three-bit terminal index limits the terminal count
  generate
    if (NUM_TERM < 1 || NUM_TERM > 8) begin : g_chk
      $error("NUM_TERM must lie in 1..8");
    end
  endgenerate

  localparam int PW = msf_pkg::PRESET_W;
  localparam int FW = msf_pkg::FUNC_W;

  // Setting registers
  logic [msf_pkg::NUM_PRESET-1:0][PW-1:0] preset;      // Speed presets
  logic [msf_pkg::NUM_PRESET-1:0][PW-1:0] next_preset;
  logic [NUM_TERM-1:0][FW-1:0] term_fn;                 // Terminal functions
  logic [NUM_TERM-1:0][FW-1:0] next_term_fn;
  logic [1:0]                  remote_fn;               // Remote function
  logic [1:0]                  next_remote_fn;
  logic [2:0]                  op_mode;                 // Operation mode
  logic [2:0]                  next_op_mode;
  logic [1:0]                  pwrite_sel;              // Write selection
  logic [1:0]                  next_pwrite_sel;
  logic [msf_pkg::DATA_W-1:0]  ugroup;                  // User group read
  logic [msf_pkg::DATA_W-1:0]  next_ugroup;
  logic [msf_pkg::DATA_W-1:0]  next_rdata;

  // Decode helpers
  logic [3:0]    slot;        // Addressed preset slot
  logic          in_preset;   // Address hits a preset slot
  logic          in_term;     // Address hits a terminal slot
  logic [2:0]    tidx;        // Addressed terminal
  logic          ext_open;    // Extended presets visible
  logic          val_ok;      // Write value in range for the slot

  // Selection path
  logic [NUM_TERM-1:0] term_sync;   // Filtered terminal levels
  logic          high_speed_select;
  logic          middle_speed_select;
  logic          low_speed_select;
  logic          speed_extension_select;
  logic          ms_enable;         // Multi-speed allowed now
  logic          dec_hit;
  logic [PW-1:0] dec_freq;
  logic [PW-1:0] next_freq_cmd;
  msf_pkg::msf_src_t next_freq_src;
  logic          next_multi_on;

  // Contacts cross in from outside the clock domain
  msf_sync #(
    .W (NUM_TERM)
  ) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .din  (term_in),
    .dout (term_sync)
  );

  // Address decode
  always_comb begin
    slot      = addr[3:0];
    in_preset = (addr < msf_pkg::OFS_PRESET_END);
    tidx      = 3'(addr - msf_pkg::OFS_TERM0);
    in_term   = (addr >= msf_pkg::OFS_TERM0) &&
                (addr < 8'(msf_pkg::OFS_TERM0 + 8'(NUM_TERM)));
    ext_open  = (ugroup == '0);
    // Basic presets stop at 400 Hz; extended also take the marker
    if (slot < 4'(msf_pkg::NUM_BASIC)) begin
      val_ok = (wdata <= msf_pkg::FREQ_MAX);
    end else begin
      val_ok = ext_open && ((wdata <= msf_pkg::FREQ_MAX) ||
               (wdata == msf_pkg::NOT_SEL));
    end
  end

  // Register writes; presets ignore mode, running state, write selection
  always_comb begin
    next_preset     = preset;
    next_term_fn    = term_fn;
    next_remote_fn  = remote_fn;
    next_op_mode    = op_mode;
    next_pwrite_sel = pwrite_sel;
    next_ugroup     = ugroup;
    if (wr) begin
      if (in_preset) begin
        if (val_ok) begin
          next_preset[slot] = wdata;
        end
      end else if (in_term) begin
        next_term_fn[tidx] = wdata[FW-1:0];
      end else begin
        case (addr)
          msf_pkg::OFS_REMOTE: next_remote_fn  = wdata[1:0];
          msf_pkg::OFS_OPMODE: next_op_mode    = wdata[2:0];
          // Stored for software only: presets never consult it
          msf_pkg::OFS_PWRITE: next_pwrite_sel = wdata[1:0];
          msf_pkg::OFS_UGROUP: next_ugroup     = wdata;
          default: ;                                     // Unmapped write
        endcase
      end
    end
  end

  // Setting registers and their reset values
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < msf_pkg::NUM_PRESET; i++) begin
        preset[i] <= msf_pkg::preset_reset(i);
      end
      for (int t = 0; t < NUM_TERM; t++) begin
        term_fn[t] <= msf_pkg::term_reset(t);
      end
      remote_fn  <= msf_pkg::RST_REMOTE;
      op_mode    <= msf_pkg::RST_OPMODE;
      pwrite_sel <= msf_pkg::RST_PWRITE;
      ugroup     <= msf_pkg::RST_UGROUP;
    end else begin
      preset     <= next_preset;
      term_fn    <= next_term_fn;
      remote_fn  <= next_remote_fn;
      op_mode    <= next_op_mode;
      pwrite_sel <= next_pwrite_sel;
      ugroup     <= next_ugroup;
    end
  end

  // Read mux; hidden presets and unmapped words read zero
  always_comb begin
    next_rdata = '0;
    if (rd) begin
      if (in_preset) begin
        if (slot < 4'(msf_pkg::NUM_BASIC) || ext_open) begin
          next_rdata = preset[slot];
        end
      end else if (in_term) begin
        next_rdata = {8'h00, term_fn[tidx]};
      end else begin
        case (addr)
          msf_pkg::OFS_REMOTE: next_rdata = {14'h0000, remote_fn};
          msf_pkg::OFS_OPMODE: next_rdata = {13'h0000, op_mode};
          msf_pkg::OFS_PWRITE: next_rdata = {14'h0000, pwrite_sel};
          msf_pkg::OFS_UGROUP: next_rdata = ugroup;
          msf_pkg::OFS_FREQ:   next_rdata = freq_cmd;
          msf_pkg::OFS_STATE: begin
            next_rdata[msf_pkg::STATE_SEL_LSB +: 4] =
              {speed_extension_select, high_speed_select,
               middle_speed_select, low_speed_select};
            next_rdata[msf_pkg::STATE_SRC_LSB +: 3] = freq_src;
            next_rdata[msf_pkg::STATE_EN_BIT]       = multi_on;
          end
          default: next_rdata = '0;
        endcase
      end
    end
  end

  // Read data stand for exactly one cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata <= '0;
    end else begin
      rdata <= next_rdata;
    end
  end

  // Route terminals onto select functions by their codes
  always_comb begin
    high_speed_select      = 1'b0;
    middle_speed_select    = 1'b0;
    low_speed_select       = 1'b0;
    speed_extension_select = 1'b0;
    for (int t = 0; t < NUM_TERM; t++) begin
      if (term_sync[t]) begin
        case (term_fn[t])
          msf_pkg::FN_HIGH: high_speed_select      = 1'b1;
          msf_pkg::FN_MID:  middle_speed_select    = 1'b1;
          msf_pkg::FN_LOW:  low_speed_select       = 1'b1;
          msf_pkg::FN_EXT:  speed_extension_select = 1'b1;
          default: ;                                        // Other use
        endcase
      end
    end
  end

  // Preset lookup for the current combination
  msf_decode u_decode (
    .sel_high (high_speed_select),
    .sel_mid  (middle_speed_select),
    .sel_low  (low_speed_select),
    .sel_ext  (speed_extension_select),
    .preset   (preset),
    .hit      (dec_hit),
    .freq     (dec_freq)
  );

  // Source priority; remote setting takes the select inputs away
  always_comb begin
    ms_enable = ((op_mode == msf_pkg::MODE_EXT) ||
                 (op_mode == msf_pkg::MODE_COMB)) &&
                (remote_fn == 2'h0);
    next_multi_on = ms_enable && dec_hit;
    next_freq_cmd = '0;
    next_freq_src = msf_pkg::SRC_NONE;
    if (jog_on) begin
      next_freq_cmd = jog_freq;
      next_freq_src = msf_pkg::SRC_JOG;
    end else if (next_multi_on) begin
      next_freq_cmd = dec_freq;
      next_freq_src = msf_pkg::SRC_MULTI;
    end else if (cur_valid) begin
      next_freq_cmd = cur_freq;
      next_freq_src = msf_pkg::SRC_CUR;
    end else if (volt_valid) begin
      next_freq_cmd = volt_freq;
      next_freq_src = msf_pkg::SRC_VOLT;
    end
  end

  // Command registered one cycle after the combination settles
  always_ff @(posedge mclk) begin
    if (rst) begin
      freq_cmd <= '0;
      freq_src <= msf_pkg::SRC_NONE;
      multi_on <= 1'b0;
    end else begin
      freq_cmd <= next_freq_cmd;
      freq_src <= next_freq_src;
      multi_on <= next_multi_on;
    end
  end

  // Checks on the selection path and register file
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Only high select asserted, multi-speed allowed, no jog
  sequence s_high_only;
    ms_enable && !jog_on && high_speed_select && !middle_speed_select &&
    !low_speed_select && !speed_extension_select;
  endsequence
  property p_high_preset;
    s_high_only |=> (freq_cmd == $past(preset[0])) &&
                    (freq_src == msf_pkg::SRC_MULTI);
  endproperty
  a_high_preset: assert property (p_high_preset)
    else $error("high select did not give high preset");

  // Middle and high with speed six unset falls to middle
  sequence s_mid_high;
    ms_enable && !jog_on && high_speed_select && middle_speed_select &&
    !low_speed_select && !speed_extension_select &&
    preset[5] == msf_pkg::NOT_SEL;
  endsequence
  property p_mid_beats_high;
    s_mid_high |=> freq_cmd == $past(preset[1]);
  endproperty
  a_mid_beats_high: assert property (p_mid_beats_high)
    else $error("middle select did not win over high");

  // Extension alone with speed eight unset runs low preset
  property p_ext_fallback;
    ms_enable && !jog_on && speed_extension_select && !high_speed_select &&
    !middle_speed_select && !low_speed_select &&
    preset[7] == msf_pkg::NOT_SEL |=> freq_cmd == $past(preset[2]);
  endproperty
  a_ext_fallback: assert property (p_ext_fallback)
    else $error("speed eight fallback to low preset failed");

  // Extension plus low picks speed nine when set
  property p_speed_nine;
    ms_enable && !jog_on && speed_extension_select && low_speed_select &&
    !high_speed_select && !middle_speed_select &&
    preset[8] != msf_pkg::NOT_SEL |=> freq_cmd == $past(preset[8]);
  endproperty
  a_speed_nine: assert property (p_speed_nine)
    else $error("speed nine not selected");

  // Mode outside 3 and 4 never yields multi-speed
  property p_mode_gate;
    (op_mode != msf_pkg::MODE_EXT) && (op_mode != msf_pkg::MODE_COMB)
      |=> freq_src != msf_pkg::SRC_MULTI;
  endproperty
  a_mode_gate: assert property (p_mode_gate)
    else $error("multi-speed used outside external modes");

  // Remote function set removes multi-speed
  property p_remote_gate;
    remote_fn != 2'h0 |=> !multi_on;
  endproperty
  a_remote_gate: assert property (p_remote_gate)
    else $error("multi-speed active with remote function set");

  // Jog wins and its frequency appears next cycle
  property p_jog_first;
    jog_on |=> (freq_src == msf_pkg::SRC_JOG) &&
               (freq_cmd == $past(jog_freq));
  endproperty
  a_jog_first: assert property (p_jog_first)
    else $error("jog did not take priority");

  // Out-of-range write to high preset leaves it unchanged
  sequence s_bad_high_write;
    wr && addr == msf_pkg::OFS_PRESET0 && wdata > msf_pkg::FREQ_MAX;
  endsequence
  property p_range_reject;
    s_bad_high_write |=> $stable(preset[0]);
  endproperty
  a_range_reject: assert property (p_range_reject)
    else $error("out-of-range preset accepted");

  // Hidden extended preset ignores writes
  property p_group_lock;
    wr && in_preset && slot >= 4'h3 && ugroup != '0 |=> $stable(preset);
  endproperty
  a_group_lock: assert property (p_group_lock)
    else $error("extended preset written while hidden");

  // Valid preset write lands in any mode and touches no other slot
  property p_write_any_mode;
    wr && addr == msf_pkg::OFS_PRESET0 && wdata <= msf_pkg::FREQ_MAX
      |=> preset[0] == $past(wdata) &&
          $stable(preset[msf_pkg::NUM_PRESET-1:1]);
  endproperty
  a_write_any_mode: assert property (p_write_any_mode)
    else $error("preset write refused");

  // After reset the first and last extended presets hold the marker
  property p_ext_reset;
    $fell(rst) |-> preset[3] == msf_pkg::NOT_SEL &&
                   preset[14] == msf_pkg::NOT_SEL;
  endproperty
  a_ext_reset: assert property (p_ext_reset)
    else $error("extended preset not reset to marker");
endmodule : msf_selector

// ### hw/msf_sync.sv
// Purpose: Three-stage synchroniser for contact inputs
// Assumes: Inputs are slow contacts from outside the clock domain
// Notes:   A change counts only once stages two and three agree
`timescale 1ns/10ps
module msf_sync #(
  parameter int W = 7
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1;       // Metastable stage, read only by s2
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_dout;

  // A zero-width chain has nothing to filter
  generate
    if (W < 1) begin : g_chk
      $error("W must be at least 1");
    end
  endgenerate

  // Accept a level once the last two stages match; one driver per bit
  generate
    for (genvar b = 0; b < W; b++) begin : g_bit
      assign next_dout[b] = (s2[b] == s3[b]) ? s3[b] : dout[b];
    end
  endgenerate

  // Stage chain and filtered output
  always_ff @(posedge mclk) begin
    if (rst) begin
      s1   <= '0;
      s2   <= '0;
      s3   <= '0;
      dout <= '0;
    end else begin
      s1   <= din;
      s2   <= s1;
      s3   <= s2;
      dout <= next_dout;
    end
  end
endmodule : msf_sync

// ### verif/msf_contacts.sv
// Purpose: Contact switch model driving the selector's terminal pins
// Assumes: Contacts are plain levels; a change lands lag+1 cycles after request
// Notes:   No bounce modelled; lag 0 is prompt, larger lag is slow
`timescale 1ns/10ps
module msf_contacts #(
  parameter int N = 7
) (
  input  wire logic         mclk,
  input  wire logic [N-1:0] want,
  input  wire logic [3:0]   lag,
  output logic      [N-1:0] contacts
);
  logic [3:0] cnt; // Cycles the request has waited
  initial begin
    contacts = '0;
    cnt = '0;
  end
  // Follow the request once it has waited lag cycles
  always @(posedge mclk) begin
    if (want === contacts) cnt <= '0;
    else if (cnt >= lag) begin
      contacts <= want;
      cnt <= '0;
    end else cnt <= cnt + 4'h1;
  end
endmodule : msf_contacts

// ### verif/tb_msf_selector.sv
// Purpose: Self-checking bench for the multi-speed frequency selector
// Assumes: Terminals 0..2 low, middle, high; slots 3..14 are speeds 4..15
// Notes:   Command settle waits are bounded at 20 cycles
`timescale 1ns/10ps
module tb_msf_selector;
  logic        mclk = 0, rst = 1, wr = 0, rd = 0;
  logic        jog_on = 0, cur_valid = 0, volt_valid = 0, multi_on;
  logic [7:0]  addr = '0;
  logic [15:0] wdata = '0, rdata, freq_cmd, jog_freq = 16'h0032;
  logic [15:0] cur_freq = 16'h00C8, volt_freq = 16'h0096, rv;
  logic [6:0]  want = '0, term_in;
  logic [3:0]  lag = '0;
  msf_pkg::msf_src_t freq_src;
  int          error_cnt = 0, total_checks = 0;

  always #4 mclk = ~mclk; // 125 MHz

  msf_selector #(.NUM_TERM(7)) DUT (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .term_in(term_in), .jog_on(jog_on),
    .jog_freq(jog_freq), .cur_valid(cur_valid), .cur_freq(cur_freq),
    .volt_valid(volt_valid), .volt_freq(volt_freq), .freq_cmd(freq_cmd),
    .freq_src(freq_src), .multi_on(multi_on));
  msf_contacts #(.N(7)) sw (.mclk(mclk), .want(want), .lag(lag), .contacts(term_in));

  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One-cycle write strobe
  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wreg

  // Read data only stand in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge mclk);
    addr <= a; rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    check(rdata, exp);
    @(posedge mclk);
  endtask : rchk

  // Sample the command mid-cycle, bounded; a stuck command ends the run
  task automatic settle(input logic [15:0] exp, input msf_pkg::msf_src_t src);
    int n;
    n = 0;
    @(negedge mclk);
    while ((freq_cmd !== exp || freq_src !== src) && n < 20) begin
      @(negedge mclk);
      n++;
    end
    check(freq_cmd, exp);
    check({13'h0000, freq_src}, {13'h0000, src});
    if (n == 20) begin
      error_cnt++;
      final_report();
    end
    @(posedge mclk);
  endtask : settle

  task automatic t_reset;
    rchk(8'h00, 16'h01F4);
    rchk(8'h01, 16'h012C);
    rchk(8'h02, 16'h0064);
    for (int i = 3; i < 15; i++) rchk(8'(i), 16'h270F);
    rchk(8'h30, 16'h0000);
    check({15'h0000, multi_on}, 16'h0000);
  endtask : t_reset

  // Basic selects, one and several at once, prompt then slow contacts
  task automatic t_basic;
    logic [6:0]  p [5] = '{7'h01, 7'h02, 7'h04, 7'h06, 7'h07};
    logic [15:0] f [5] = '{16'h0064, 16'h012C, 16'h01F4, 16'h012C, 16'h0064};
    wreg(msf_pkg::OFS_OPMODE, 16'h0003);
    for (int i = 0; i < 5; i++) begin
      lag <= 4'(i);
      want <= p[i];
      settle(f[i], msf_pkg::SRC_MULTI);
    end
  endtask : t_basic

  // Extension select on terminal 3, fallback and extended slots
  task automatic t_ext;
    want <= 7'h00;
    settle(16'h0000, msf_pkg::SRC_NONE);
    wreg(8'h1B, 16'h0008);
    wreg(msf_pkg::OFS_OPMODE, 16'h0004);
    want <= 7'h08;
    settle(16'h0064, msf_pkg::SRC_MULTI);
    wreg(msf_pkg::OFS_PWRITE, 16'h0001);
    wreg(8'h07, 16'h04D2);
    settle(16'h04D2, msf_pkg::SRC_MULTI);
    want <= 7'h09;
    settle(16'h0064, msf_pkg::SRC_MULTI);
    wreg(8'h08, 16'h0123);
    settle(16'h0123, msf_pkg::SRC_MULTI);
    wreg(8'h04, 16'h0FA0);
    rchk(8'h04, 16'h0FA0);
    wreg(8'h04, 16'h0FA1);
    rchk(8'h04, 16'h0FA0);
    rchk(msf_pkg::OFS_PWRITE, 16'h0001);
    wreg(8'h00, 16'h0FA0);
    rchk(8'h00, 16'h0FA0);
    wreg(8'h00, 16'h270F);
    rchk(8'h00, 16'h0FA0);
  endtask : t_ext

  // Source priority, remote and mode gating, user group hiding
  task automatic t_gate;
    want <= 7'h01;
    cur_valid <= 1'b1;
    volt_valid <= 1'b1;
    settle(16'h0064, msf_pkg::SRC_MULTI);
    wreg(msf_pkg::OFS_REMOTE, 16'h0001);
    settle(16'h00C8, msf_pkg::SRC_CUR);
    rchk(msf_pkg::OFS_STATE, 16'h0031);
    cur_valid <= 1'b0;
    settle(16'h0096, msf_pkg::SRC_VOLT);
    wreg(msf_pkg::OFS_REMOTE, 16'h0000);
    wreg(msf_pkg::OFS_OPMODE, 16'h0000);
    repeat (4) @(posedge mclk);
    settle(16'h0096, msf_pkg::SRC_VOLT);
    wreg(msf_pkg::OFS_OPMODE, 16'h0003);
    settle(16'h0064, msf_pkg::SRC_MULTI);
    jog_on <= 1'b1;
    settle(16'h0032, msf_pkg::SRC_JOG);
    rchk(msf_pkg::OFS_STATE, 16'h0091);
    rchk(msf_pkg::OFS_FREQ, 16'h0032);
    wreg(msf_pkg::OFS_UGROUP, 16'h0001);
    rchk(8'h03, 16'h0000);
    wreg(8'h03, 16'h0100);
    wreg(msf_pkg::OFS_UGROUP, 16'h0000);
    rchk(8'h03, 16'h270F);
  endtask : t_gate

  // Mid-run reset restores written presets and mode
  task automatic t_rerun;
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rchk(8'h07, 16'h270F);
    rchk(8'h00, 16'h01F4);
    rchk(msf_pkg::OFS_OPMODE, 16'h0000);
  endtask : t_rerun

  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_basic();
    t_ext();
    t_gate();
    t_rerun();
    final_report();
  end
endmodule : tb_msf_selector
